// File: hw/akm_pkg.sv
// shared constants and types of the admin keypad menu and lockout block
`default_nettype none
package akm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SEC_MS = 1000;
  localparam int SEC_CYC = CLK_HZ / 1000 * SEC_MS;
  localparam int MIN_SEC = 60;
  localparam int CLICK_GAP_MS = 500;
  localparam int CLICK_GAP_CYC = CLK_HZ / 1000 * CLICK_GAP_MS;
  localparam int SHOW_MS = 1000;
  localparam int SHOW_CYC = CLK_HZ / 1000 * SHOW_MS;
  localparam int FLICK_MS = 50;
  localparam int FLICK_CYC = CLK_HZ / 1000 * FLICK_MS;
  localparam int BLINK_MS = 500;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  // ----------------------------------------------------------------
  // codes, limits and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] FAIL_LIMIT = 4'ha;
  localparam logic [3:0] FAIL_RST = 4'h0;
  localparam logic [1:0] CLICK_ONE = 2'h1;
  localparam logic [1:0] CLICK_MENU = 2'h3;
  localparam logic [3:0] CODE_TMO_HI = 4'h8;
  localparam logic [3:0] CODE_TMO_LO = 4'h5;
  localparam logic [3:0] CODE_ERASE_HI = 4'h3;
  localparam logic [3:0] CODE_ERASE_LO = 4'h2;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [1:0] CODE_DIGITS = 2'h2;
  localparam logic [6:0] TMO_RST = 7'h00;
  localparam logic [6:0] TMO_MAX = 7'h63;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_LOCKED = 8'h01, ST_ADMIN = 8'h02, ST_USER = 8'h04, ST_MENU = 8'h08,
    ST_TMO = 8'h10, ST_ERASE = 8'h20, ST_SHOW = 8'h40, ST_WIPED = 8'h80
  } akm_state_t;
  typedef enum logic [2:0] {
    PAT_OFF, PAT_FLICK_G, PAT_FLICK_GB, PAT_BLINK_G, PAT_ALT_RG,
    PAT_SOLID_R, PAT_SOLID_RG, PAT_SOLID_G
  } akm_pat_t;
  typedef struct packed {logic valid; logic admin; logic match;} akm_pin_res_t;
  typedef struct packed {logic red; logic green; logic blue;} akm_led_t;
  typedef struct packed {logic user_pin; logic admin_pin; logic key; logic data;} akm_erase_t;
endpackage
`default_nettype wire

// File: hw/akm_click.sv
// groups key presses into single, double and triple clicks
`default_nettype none
module akm_click
  import akm_pkg::*;
#(
  parameter int GAP_CYC = CLICK_GAP_CYC
)
(
  input wire logic mclk, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic key_press, // one-cycle key press
  output logic click_evt, // one-cycle group done
  output logic [1:0] click_cnt // presses in group, saturating
);
  localparam int GW = $clog2(GAP_CYC + 1);
  logic [GW-1:0] gap_reg, gap_next;
  logic [1:0] cnt_reg, cnt_next;
  logic evt_next;
  logic [1:0] out_next;
  always_comb
  begin
    gap_next = gap_reg;
    cnt_next = cnt_reg;
    evt_next = 1'b0;
    out_next = click_cnt;
    if (key_press)
    begin
      gap_next = GW'(GAP_CYC);
      cnt_next = (cnt_reg == 2'h3) ? cnt_reg : cnt_reg + 2'h1;
    end
    else if (gap_reg != '0)
    begin
      gap_next = gap_reg - GW'(1);
      if (gap_reg == GW'(1))
      begin
        evt_next = 1'b1;
        out_next = cnt_reg;
        cnt_next = 2'h0;
      end
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      gap_reg <= '0;
      cnt_reg <= 2'h0;
      click_evt <= 1'b0;
      click_cnt <= 2'h0;
    end
    else
    begin
      gap_reg <= gap_next;
      cnt_reg <= cnt_next;
      click_evt <= evt_next;
      click_cnt <= out_next;
    end
  end
endmodule
`default_nettype wire

// File: hw/akm_led.sv
// turns a display pattern into red, green and blue drive
`default_nettype none
module akm_led
  import akm_pkg::*;
#(
  parameter int FL_CYC = FLICK_CYC,
  parameter int BL_CYC = BLINK_CYC
)
(
  input wire logic mclk, // system clock
  input wire logic resetn, // sync reset, active low
  input wire akm_pat_t pat, // pattern to show
  output akm_led_t led // led drive, registered
);
  localparam int FW = $clog2(FL_CYC + 1);
  localparam int BW = $clog2(BL_CYC + 1);
  logic [FW-1:0] fdiv_reg, fdiv_next;
  logic [BW-1:0] bdiv_reg, bdiv_next;
  logic fph_reg, fph_next, bph_reg, bph_next;
  akm_led_t led_next;
  always_comb
  begin
    fdiv_next = (fdiv_reg == FW'(FL_CYC - 1)) ? '0 : fdiv_reg + FW'(1);
    bdiv_next = (bdiv_reg == BW'(BL_CYC - 1)) ? '0 : bdiv_reg + BW'(1);
    fph_next = (fdiv_reg == FW'(FL_CYC - 1)) ? !fph_reg : fph_reg;
    bph_next = (bdiv_reg == BW'(BL_CYC - 1)) ? !bph_reg : bph_reg;
    case (pat)
      PAT_FLICK_G: led_next = '{1'b0, fph_reg, 1'b0};
      PAT_FLICK_GB: led_next = '{1'b0, fph_reg, fph_reg};
      PAT_BLINK_G: led_next = '{1'b0, bph_reg, 1'b0};
      PAT_ALT_RG: led_next = '{bph_reg, !bph_reg, 1'b0};
      PAT_SOLID_R: led_next = '{1'b1, 1'b0, 1'b0};
      PAT_SOLID_RG: led_next = '{1'b1, 1'b1, 1'b0};
      PAT_SOLID_G: led_next = '{1'b0, 1'b1, 1'b0};
      default: led_next = '{1'b0, 1'b0, 1'b0};
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      fdiv_reg <= '0;
      bdiv_reg <= '0;
      fph_reg <= 1'b0;
      bph_reg <= 1'b0;
      led <= '{1'b0, 1'b0, 1'b0};
    end
    else
    begin
      fdiv_reg <= fdiv_next;
      bdiv_reg <= bdiv_next;
      fph_reg <= fph_next;
      bph_reg <= bph_next;
      led <= led_next;
    end
  end
endmodule
`default_nettype wire

// File: hw/akm_top.sv
// admin keypad menu, idle auto-lock and brute-force lockout controller
//
// Function
// - admin unlock shows flickering green
// - triple key click opens admin menu
// - code 85 plus click enters timeout entry
// - timeout entry takes 0 to 99 minutes
// - click stores timeout, red, then flicker green
// - timeout value 0 disables idle lock
// - disable confirmed shows red then flicker green
// - code 32 plus click enters erase confirmation
// - admin PIN in confirmation erases data only
// - erase done shows red+green then flicker green
// - admin unlock deletes user PIN
// - ten user misses, both PINs: drop user
// - ten admin misses wipe everything
// - user-only ten misses wipe everything
// - admin-only ten misses wipe everything
// - wipe makes new key, needs new PIN
// - idle for set minutes locks drive
// - admin timeout overrides user timeout
`default_nettype none
module akm_top
  import akm_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int GAP_CYCLES = CLICK_GAP_CYC,
  parameter int SHOW_CYCLES = SHOW_CYC,
  parameter int FLICK_CYCLES = FLICK_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC
)
(
  input wire logic mclk, // system clock, 20 MHz
  input wire logic resetn, // sync reset, active low
  input wire logic key_press, // one-cycle key button press
  input wire logic digit_valid, // one-cycle digit press
  input wire logic [3:0] digit, // digit value 0..9
  input wire akm_pin_res_t pin_res, // pin compare result
  input wire logic admin_pin_set, // admin pin exists
  input wire logic user_pin_set, // user pin exists
  input wire logic [6:0] user_tmo, // user timeout minutes
  input wire logic host_activity, // one-cycle host access
  input wire logic pin_created, // one-cycle new pin made
  output akm_led_t led, // led drive
  output akm_erase_t erase_cmd, // one-cycle delete commands
  output logic gen_key, // one-cycle new key request
  output logic lock_drive, // one-cycle idle lock
  output logic need_new_pin, // wiped, waiting for pin
  output logic admin_unlocked, // admin session open
  output logic [6:0] tmo_minutes // effective timeout
);
  // ----------------------------------------------------------------
  // click grouping
  // ----------------------------------------------------------------
  logic click_evt;
  logic [1:0] click_cnt;
  akm_click #(.GAP_CYC(GAP_CYCLES)) u_click (
    .mclk(mclk),
    .resetn(resetn),
    .key_press(key_press),
    .click_evt(click_evt),
    .click_cnt(click_cnt)
  );
  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  localparam int SW = $clog2(SHOW_CYCLES + 1);
  akm_state_t state_reg, state_next;
  logic [3:0] d0_reg, d0_next, d1_reg, d1_next;
  logic [1:0] nd_reg, nd_next;
  logic [6:0] acc_reg, acc_next;
  logic [1:0] nacc_reg, nacc_next;
  logic [6:0] admin_tmo_reg, admin_tmo_next;
  logic admin_tmo_set_reg, admin_tmo_set_next;
  logic [3:0] afail_reg, afail_next, ufail_reg, ufail_next;
  akm_pat_t show_pat_reg, show_pat_next;
  logic [SW-1:0] show_reg, show_next;
  akm_erase_t erase_next;
  logic gen_key_next, lock_next;
  logic tmo_hit;
  logic unlocked;
  logic one_click;
  assign one_click = click_evt && (click_cnt == CLICK_ONE);
  assign unlocked = !(state_reg inside {ST_LOCKED, ST_WIPED});
  always_comb
  begin
    state_next = state_reg;
    d0_next = d0_reg;
    d1_next = d1_reg;
    nd_next = nd_reg;
    acc_next = acc_reg;
    nacc_next = nacc_reg;
    admin_tmo_next = admin_tmo_reg;
    admin_tmo_set_next = admin_tmo_set_reg;
    afail_next = afail_reg;
    ufail_next = ufail_reg;
    show_pat_next = show_pat_reg;
    show_next = show_reg;
    erase_next = '{1'b0, 1'b0, 1'b0, 1'b0};
    gen_key_next = 1'b0;
    lock_next = 1'b0;
    case (state_reg)
      ST_LOCKED:
      begin
        if (pin_res.valid && pin_res.admin)
        begin
          if (pin_res.match)
          begin
            state_next = ST_ADMIN;
            erase_next.user_pin = 1'b1;
            afail_next = FAIL_RST;
          end
          else if (afail_reg == FAIL_LIMIT - 4'h1)
          begin
            erase_next = '{1'b1, 1'b1, 1'b1, 1'b1};
            gen_key_next = 1'b1;
            state_next = ST_WIPED;
            afail_next = FAIL_RST;
            ufail_next = FAIL_RST;
          end
          else
            afail_next = afail_reg + 4'h1;
        end
        else if (pin_res.valid)
        begin
          if (pin_res.match)
          begin
            state_next = ST_USER;
            ufail_next = FAIL_RST;
          end
          else if (ufail_reg == FAIL_LIMIT - 4'h1)
          begin
            ufail_next = FAIL_RST;
            if (admin_pin_set)
              erase_next.user_pin = 1'b1;
            else
            begin
              erase_next = '{1'b1, 1'b1, 1'b1, 1'b1};
              gen_key_next = 1'b1;
              state_next = ST_WIPED;
              afail_next = FAIL_RST;
            end
          end
          else
            ufail_next = ufail_reg + 4'h1;
        end
      end
      ST_ADMIN:
      begin
        if (click_evt && (click_cnt == CLICK_MENU))
        begin
          state_next = ST_MENU;
          nd_next = 2'h0;
        end
      end
      ST_MENU:
      begin
        if (digit_valid)
        begin
          d1_next = d0_reg;
          d0_next = digit;
          nd_next = (nd_reg == CODE_DIGITS) ? nd_reg : nd_reg + 2'h1;
        end
        if (click_evt)
        begin
          state_next = ST_ADMIN;
          if (one_click && (nd_reg == CODE_DIGITS))
          begin
            if ((d1_reg == CODE_TMO_HI) && (d0_reg == CODE_TMO_LO))
            begin
              state_next = ST_TMO;
              acc_next = TMO_RST;
              nacc_next = 2'h0;
            end
            else if ((d1_reg == CODE_ERASE_HI) && (d0_reg == CODE_ERASE_LO))
              state_next = ST_ERASE;
          end
        end
      end
      ST_TMO:
      begin
        if (digit_valid && (digit <= DIGIT_MAX) && (nacc_reg != CODE_DIGITS))
        begin
          acc_next = 7'(acc_reg * 7'h0a + {3'h0, digit});
          nacc_next = nacc_reg + 2'h1;
        end
        if (one_click)
        begin
          admin_tmo_next = acc_reg;
          admin_tmo_set_next = 1'b1;
          show_pat_next = PAT_SOLID_R;
          show_next = '0;
          state_next = ST_SHOW;
        end
        else if (click_evt)
          state_next = ST_ADMIN;
      end
      ST_ERASE:
      begin
        if (pin_res.valid && pin_res.admin && pin_res.match)
        begin
          erase_next.data = 1'b1;
          show_pat_next = PAT_SOLID_RG;
          show_next = '0;
          state_next = ST_SHOW;
        end
        else if (pin_res.valid || (click_evt && !one_click))
          state_next = ST_ADMIN;
      end
      ST_SHOW:
      begin
        show_next = show_reg + SW'(1);
        if (show_reg == SW'(SHOW_CYCLES - 1))
          state_next = ST_ADMIN;
      end
      ST_WIPED:
      begin
        if (pin_created)
          state_next = ST_LOCKED;
      end
      ST_USER:
        state_next = ST_USER;
      default:
        state_next = ST_LOCKED;
    endcase
    if (tmo_hit)
    begin
      state_next = ST_LOCKED;
      lock_next = 1'b1;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg <= ST_LOCKED;
      d0_reg <= 4'h0;
      d1_reg <= 4'h0;
      nd_reg <= 2'h0;
      acc_reg <= TMO_RST;
      nacc_reg <= 2'h0;
      admin_tmo_reg <= TMO_RST;
      admin_tmo_set_reg <= 1'b0;
      afail_reg <= FAIL_RST;
      ufail_reg <= FAIL_RST;
      show_pat_reg <= PAT_SOLID_R;
      show_reg <= '0;
      erase_cmd <= '{1'b0, 1'b0, 1'b0, 1'b0};
      gen_key <= 1'b0;
      lock_drive <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      d0_reg <= d0_next;
      d1_reg <= d1_next;
      nd_reg <= nd_next;
      acc_reg <= acc_next;
      nacc_reg <= nacc_next;
      admin_tmo_reg <= admin_tmo_next;
      admin_tmo_set_reg <= admin_tmo_set_next;
      afail_reg <= afail_next;
      ufail_reg <= ufail_next;
      show_pat_reg <= show_pat_next;
      show_reg <= show_next;
      erase_cmd <= erase_next;
      gen_key <= gen_key_next;
      lock_drive <= lock_next;
    end
  end
  // ----------------------------------------------------------------
  // idle timer
  // ----------------------------------------------------------------
  localparam int CW = $clog2(SEC_CYCLES + 1);
  logic [CW-1:0] sec_reg, sec_next;
  logic [5:0] secs_reg, secs_next;
  logic [6:0] min_reg, min_next;
  logic [6:0] tmo_next;
  logic activity;
  assign activity = host_activity || key_press || digit_valid;
  assign tmo_hit = unlocked && (tmo_minutes != 7'h00) && (min_reg >= tmo_minutes);
  always_comb
  begin
    tmo_next = admin_tmo_set_reg ? admin_tmo_reg : user_tmo;
    if (tmo_next > TMO_MAX)
      tmo_next = TMO_MAX;
    sec_next = sec_reg + CW'(1);
    secs_next = secs_reg;
    min_next = min_reg;
    if (!unlocked || activity || tmo_hit)
    begin
      sec_next = '0;
      secs_next = 6'h00;
      min_next = 7'h00;
    end
    else if (sec_reg == CW'(SEC_CYCLES - 1))
    begin
      sec_next = '0;
      secs_next = secs_reg + 6'h01;
      if (secs_reg == 6'(MIN_SEC - 1))
      begin
        secs_next = 6'h00;
        min_next = (min_reg == 7'h7f) ? min_reg : min_reg + 7'h01;
      end
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sec_reg <= '0;
      secs_reg <= 6'h00;
      min_reg <= 7'h00;
      tmo_minutes <= TMO_RST;
    end
    else
    begin
      sec_reg <= sec_next;
      secs_reg <= secs_next;
      min_reg <= min_next;
      tmo_minutes <= tmo_next;
    end
  end
  // ----------------------------------------------------------------
  // display and status
  // ----------------------------------------------------------------
  akm_pat_t pat;
  always_comb
  begin
    case (state_reg)
      ST_ADMIN: pat = PAT_FLICK_G;
      ST_USER: pat = PAT_SOLID_G;
      ST_MENU: pat = PAT_FLICK_GB;
      ST_TMO: pat = PAT_BLINK_G;
      ST_ERASE: pat = PAT_ALT_RG;
      ST_SHOW: pat = show_pat_reg;
      ST_WIPED: pat = PAT_SOLID_R;
      default: pat = PAT_OFF;
    endcase
  end
  akm_led #(.FL_CYC(FLICK_CYCLES), .BL_CYC(BLINK_CYCLES)) u_led (
    .mclk(mclk),
    .resetn(resetn),
    .pat(pat),
    .led(led)
  );
  assign need_new_pin = (state_reg == ST_WIPED);
  assign admin_unlocked = state_reg inside {ST_ADMIN, ST_MENU, ST_TMO, ST_ERASE, ST_SHOW};
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_MENU_OPEN: assert property (
    state_reg == ST_ADMIN && click_evt && click_cnt == CLICK_MENU && !tmo_hit
    |=> state_reg == ST_MENU ##1 led.red == 1'b0)
    else $error("triple click did not open menu");
  AST_TMO_CODE: assert property (
    state_reg == ST_MENU && one_click && nd_reg == 2'h2 && d1_reg == 4'h8
    && d0_reg == 4'h5 && !tmo_hit |=> state_reg == ST_TMO && acc_reg == 7'h00)
    else $error("code 85 did not enter timeout entry");
  AST_ERASE_CODE: assert property (
    state_reg == ST_MENU && one_click && nd_reg == 2'h2 && d1_reg == 4'h3
    && d0_reg == 4'h2 && !tmo_hit |=> state_reg == ST_ERASE)
    else $error("code 32 did not enter erase confirmation");
  AST_TMO_STORE: assert property (
    state_reg == ST_TMO && one_click && !tmo_hit
    |=> admin_tmo_reg == $past(acc_reg) && state_reg == ST_SHOW
    && show_pat_reg == PAT_SOLID_R ##1 tmo_minutes == $past(acc_reg, 2))
    else $error("timeout value not stored");
  AST_SHOW_END: assert property (
    state_reg == ST_SHOW && show_reg == SW'(SHOW_CYCLES - 1) && !tmo_hit
    |=> state_reg == ST_ADMIN)
    else $error("confirmation display did not return");
  AST_ADMIN_UNLOCK: assert property (
    state_reg == ST_LOCKED && pin_res.valid && pin_res.admin && pin_res.match
    |=> erase_cmd.user_pin && !erase_cmd.data && state_reg == ST_ADMIN && afail_reg == 4'h0)
    else $error("admin unlock did not drop user pin");
  AST_ADMIN_WIPE: assert property (
    state_reg == ST_LOCKED && pin_res.valid && pin_res.admin && !pin_res.match
    && afail_reg == 4'h9 |=> erase_cmd == 4'hf && gen_key ##1 need_new_pin)
    else $error("tenth admin miss did not wipe");
  AST_USER_DROP: assert property (
    state_reg == ST_LOCKED && pin_res.valid && !pin_res.admin && !pin_res.match
    && ufail_reg == 4'h9 && admin_pin_set
    |=> erase_cmd == 4'h8 && !gen_key && state_reg == ST_LOCKED)
    else $error("tenth user miss with admin pin wrong action");
  AST_USER_WIPE: assert property (
    state_reg == ST_LOCKED && pin_res.valid && !pin_res.admin && !pin_res.match
    && ufail_reg == 4'h9 && !admin_pin_set |=> erase_cmd == 4'hf && state_reg == ST_WIPED)
    else $error("tenth user miss did not wipe");
  AST_FAIL_COUNT: assert property (
    state_reg == ST_LOCKED && pin_res.valid && !pin_res.admin && !pin_res.match
    && ufail_reg < 4'h9 |=> ufail_reg == $past(ufail_reg) + 4'h1)
    else $error("user miss not counted");
  AST_ERASE_DATA: assert property (
    state_reg == ST_ERASE && pin_res.valid && pin_res.admin && pin_res.match && !tmo_hit
    |=> erase_cmd == 4'h1 && $stable(admin_tmo_reg) && show_pat_reg == PAT_SOLID_RG)
    else $error("erase did not delete data alone");
  AST_IDLE_LOCK: assert property (
    tmo_hit |=> lock_drive && state_reg == ST_LOCKED ##1 !lock_drive)
    else $error("idle timeout did not lock");
  AST_PRECEDENCE: assert property (
    admin_tmo_set_reg && $stable(admin_tmo_reg) |=> tmo_minutes == $past(admin_tmo_reg))
    else $error("admin timeout not in force");
  AST_ABORT: assert property (
    state_reg == ST_MENU && click_evt && !(nd_reg == 2'h2 && one_click) && !tmo_hit
    |=> state_reg == ST_ADMIN && $stable(admin_tmo_reg) && erase_cmd == 4'h0)
    else $error("abort changed settings");
  AST_WIPED_HOLD: assert property (
    state_reg == ST_WIPED && !pin_created |=> state_reg == ST_WIPED && !admin_unlocked)
    else $error("wiped device usable without new pin");
  COV_MENU: cover property (state_reg == ST_ADMIN ##1 state_reg == ST_MENU);
  COV_STORE: cover property (state_reg == ST_TMO ##1 state_reg == ST_SHOW);
  COV_ERASE: cover property (state_reg == ST_ERASE ##1 erase_cmd.data);
  COV_WIPE: cover property (state_reg == ST_LOCKED ##1 state_reg == ST_WIPED);
endmodule
`default_nettype wire

// File: testbench/akm_operator.sv
// keypad operator model: key clicks, digit presses and pin compare results
`default_nettype none
module akm_operator
  import akm_pkg::*;
(
  input wire logic mclk, // system clock
  output logic key_press, // key button pulse
  output logic digit_valid, // digit button pulse
  output logic [3:0] digit, // digit value
  output akm_pin_res_t pin_res // pin compare result
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    key_press = 1'b0;
    digit_valid = 1'b0;
    digit = 4'h0;
    pin_res = '0;
  end
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  // presses one idle cycle apart form one group; the wait lets the group close
  task automatic click(input int n);
    for (int i = 0; i < n; i++)
    begin
      tick();
      key_press = 1'b1;
      tick();
      key_press = 1'b0;
    end
    repeat (8) tick();
  endtask
  // digit lines show the inverse value outside the press
  task automatic dig(input logic [3:0] d);
    tick();
    digit_valid = 1'b1;
    digit = d;
    tick();
    digit_valid = 1'b0;
    digit = ~d;
  endtask
  task automatic pin(input logic adm, input logic ok);
    tick();
    pin_res = '{1'b1, adm, ok};
    tick();
    pin_res = '{1'b0, ~adm, ~ok};
    repeat (2) tick();
  endtask
endmodule
`default_nettype wire

// File: testbench/akm_top_tb_top.sv
// self-checking bench of the admin keypad menu and lockout controller
`default_nettype none
module akm_top_tb_top;
  import akm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn, key_press, digit_valid, admin_pin_set, user_pin_set;
  logic host_activity, pin_created, gen_key, lock_drive, need_new_pin, admin_unlocked;
  logic [3:0] digit, d1, d2;
  logic [6:0] user_tmo, tmo_minutes;
  akm_pin_res_t pin_res;
  akm_led_t led;
  akm_erase_t erase_cmd;
  logic [5:0] exp_q[$];
  int err_total, total_checks, seed, cyc;
  always #25 mclk = ~mclk;
  akm_operator op (.mclk(mclk), .key_press(key_press), .digit_valid(digit_valid),
    .digit(digit), .pin_res(pin_res));
  akm_top #(.SEC_CYCLES(4), .GAP_CYCLES(3), .SHOW_CYCLES(5), .FLICK_CYCLES(2),
    .BLINK_CYCLES(4)) uut (.mclk(mclk), .resetn(resetn), .key_press(key_press),
    .digit_valid(digit_valid), .digit(digit), .pin_res(pin_res),
    .admin_pin_set(admin_pin_set), .user_pin_set(user_pin_set), .user_tmo(user_tmo),
    .host_activity(host_activity), .pin_created(pin_created), .led(led),
    .erase_cmd(erase_cmd), .gen_key(gen_key), .lock_drive(lock_drive),
    .need_new_pin(need_new_pin), .admin_unlocked(admin_unlocked),
    .tmo_minutes(tmo_minutes));
  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] want);
    total_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // menu walk: triple click, two code digits, single click
  task automatic menu(input logic [3:0] hi, input logic [3:0] lo);
    op.click(3);
    op.dig(hi);
    op.dig(lo);
    op.click(1);
  endtask
  // every pulse result is matched against the oldest note
  always @(posedge mclk)
  begin
    #2;
    if (erase_cmd !== 4'h0 || gen_key !== 1'b0 || lock_drive !== 1'b0)
    begin
      if (exp_q.size() == 0)
        check("unexpected pulse", {erase_cmd, gen_key, lock_drive}, 7'h00);
      else
        check("pulse", {erase_cmd, gen_key, lock_drive}, exp_q.pop_front());
    end
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_total++;
      close_out();
    end
  end
  initial
  begin
    seed = 47;
    {err_total, total_checks, cyc} = '0;
    resetn = 1'b0;
    admin_pin_set = 1'b1;
    user_pin_set = 1'b1;
    user_tmo = 7'(($random(seed) & 32'h7fffffff) % 100);
    host_activity = 1'b0;
    pin_created = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    resetn = 1'b1;
    op.tick();
    check("led", led, 7'h00);
    repeat (9) op.pin(1'b1, 1'b0);
    exp_q.push_back(6'h20);
    op.pin(1'b1, 1'b1);
    check("admin_unlocked", admin_unlocked, 7'h01);
    check("tmo_minutes", tmo_minutes, user_tmo);
    d1 = 4'(($random(seed) & 32'h7fffffff) % 10);
    d2 = 4'(($random(seed) & 32'h7fffffff) % 10);
    menu(4'h8, 4'h5);
    op.dig(d1);
    op.dig(d2);
    op.click(1);
    repeat (8) op.tick();
    check("tmo_minutes", tmo_minutes, 7'(d1 * 10 + d2));
    menu(4'h1, 4'h2);
    check("tmo_minutes", tmo_minutes, 7'(d1 * 10 + d2));
    check("admin_unlocked", admin_unlocked, 7'h01);
    exp_q.push_back(6'h04);
    menu(4'h3, 4'h2);
    op.pin(1'b1, 1'b1);
    check("admin_unlocked", admin_unlocked, 7'h01);
    menu(4'h8, 4'h5);
    op.dig(4'h0);
    op.dig(4'h1);
    op.click(1);
    check("tmo_minutes", tmo_minutes, 7'h01);
    exp_q.push_back(6'h01);
    repeat (100) op.tick();
    host_activity = 1'b1;
    op.tick();
    host_activity = 1'b0;
    check("admin_unlocked", admin_unlocked, 7'h01);
    repeat (250) op.tick();
    check("admin_unlocked", admin_unlocked, 7'h00);
    repeat (9) op.pin(1'b1, 1'b0);
    repeat (9) op.pin(1'b0, 1'b0);
    exp_q.push_back(6'h20);
    op.pin(1'b0, 1'b0);
    check("need_new_pin", need_new_pin, 7'h00);
    exp_q.push_back(6'h3e);
    op.pin(1'b1, 1'b0);
    check("need_new_pin", need_new_pin, 7'h01);
    check("led", led, 7'h04);
    admin_pin_set = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      op.tick();
      pin_created = 1'b1;
      op.tick();
      pin_created = 1'b0;
      op.tick();
      check("need_new_pin", need_new_pin, 7'h00);
      admin_pin_set = k[0];
      user_pin_set = ~k[0];
      repeat (9) op.pin(k[0], 1'b0);
      exp_q.push_back(6'h3e);
      op.pin(k[0], 1'b0);
      check("need_new_pin", need_new_pin, 7'h01);
    end
    check("notes left", 7'(exp_q.size()), 7'h00);
    close_out();
  end
endmodule
`default_nettype wire
